// ==== pkg/dcache_perf_pkg.sv ====
// Constants, register map and carrier types for the data cache event selector.
// Assumes a single core clock domain and an AHB-Lite register bus.
package dcache_perf_pkg;

  localparam int unsigned CODE_W     = 12;
  localparam int unsigned MASK_W     = 8;

  // Register byte offsets
  localparam logic [7:0]  OFS_SELECT = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;

  // Field positions in the select register
  localparam int unsigned CODE_LSB   = 0;
  localparam int unsigned MASK_LSB   = 16;
  localparam int unsigned REVC_BIT   = 31;

  // Field positions in the status register
  localparam int unsigned INC_LSB    = 0;
  localparam int unsigned KNOWN_BIT  = 8;

  // Values after reset
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
  localparam logic [MASK_W-1:0] MASK_RESET = 8'h00;
  localparam logic              REVC_RESET = 1'b1;

  // Event codes
  localparam logic [CODE_W-1:0] EV_CLFLUSH   = 12'h026;
  localparam logic [CODE_W-1:0] EV_CPUID     = 12'h027;
  localparam logic [CODE_W-1:0] EV_STLF      = 12'h02A;
  localparam logic [CODE_W-1:0] EV_SMI       = 12'h02B;
  localparam logic [CODE_W-1:0] EV_ACCESS    = 12'h040;
  localparam logic [CODE_W-1:0] EV_MISS      = 12'h041;
  localparam logic [CODE_W-1:0] EV_REFILL    = 12'h042;
  localparam logic [CODE_W-1:0] EV_NB_REFILL = 12'h043;
  localparam logic [CODE_W-1:0] EV_EVICT     = 12'h044;
  localparam logic [CODE_W-1:0] EV_TLB_L2HIT = 12'h045;
  localparam logic [CODE_W-1:0] EV_TLB_MISS  = 12'h046;
  localparam logic [CODE_W-1:0] EV_MISALIGN  = 12'h047;
  localparam logic [CODE_W-1:0] EV_ECC       = 12'h04A;
  localparam logic [CODE_W-1:0] EV_PREFETCH  = 12'h04B;
  localparam logic [CODE_W-1:0] EV_LOCK_MISS = 12'h04C;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Occurrence strobes from the load/store unit, one cycle each
  typedef struct packed {
    logic       clflush_retired;
    logic       cpuid_retired;
    logic [2:0] stlf_cancel;       // misaligned, narrower, address mismatch
    logic       smi_received;
    logic       dc_access;
    logic       misaligned;
    logic       dc_miss;
    logic       miss_line_pending;
    logic       miss_streaming;
    logic       miss_locked;
    logic [3:0] refill_l2_state;   // modified, owned, exclusive, shared
    logic [4:0] refill_nb_state;   // modified, owned, exclusive, shared, invalid
    logic [4:0] evict_state;       // modified, owned, exclusive, shared, invalid
    logic       evict_nontemporal;
    logic [2:0] tlb_l2_hit;        // 1G, 2M, 4K
    logic [2:0] tlb_miss;          // 1G, 2M, 4K
    logic [3:0] ecc_corrected;     // store pipe, load pipe, piggyback, scrubber
    logic [2:0] prefetch_dispatch; // nontemporal, write intent, load
    logic       prefetch_collide;
  } ls_events_s;

  typedef struct packed {
    logic              rev_c;
    logic [MASK_W-1:0] sub_event_mask;
    logic [CODE_W-1:0] event_code_field;
  } sel_cfg_s;

endpackage

// ==== design/event_mask_match.sv ====
// Sub-event matcher: any strobe whose mask bit is set gives a hit.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module event_mask_match #(
  parameter int unsigned W = 3
) (
  input  wire logic [W-1:0] strobes,
  input  wire logic [W-1:0] mask,
  output logic              hit
);

  assign hit = |(strobes & mask);

endmodule
`default_nettype wire

// ==== design/dcache_perf_event_select.sv ====
// Event-source decoder for one performance counter: load/store and data cache events.
// Assumes occurrence strobes synchronous to hclk; counter itself lives outside.
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module dcache_perf_event_select
  import dcache_perf_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire ls_events_s  events,
  output logic [1:0]       count_increment,
  output logic             code_known
);

  // Register bus slave

  logic             wr_pend;
  logic [7:0]       wr_addr;
  sel_cfg_s         cfg;
  logic [1:0]       last_inc;

  wire              bus_take;
  wire              take_write;
  wire              take_read;
  wire              hit_select_rd;
  wire              hit_status_rd;
  wire              hit_select_wr;
  wire [31:0]       select_word;
  wire [31:0]       status_word;
  wire [31:0]       next_hrdata;
  wire              size_word;

  assign size_word     = (hsize == 3'h2);
  assign bus_take      = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign take_write    = bus_take & hwrite & size_word;
  assign take_read     = bus_take & ~hwrite;
  assign hit_select_rd = take_read & (haddr[7:0] == OFS_SELECT) & (haddr[31:8] == 24'h00_0000);
  assign hit_status_rd = take_read & (haddr[7:0] == OFS_STATUS) & (haddr[31:8] == 24'h00_0000);
  assign hit_select_wr = wr_pend & (wr_addr == OFS_SELECT);

  assign select_word = (32'(cfg.event_code_field) << CODE_LSB)
                     | (32'(cfg.sub_event_mask) << MASK_LSB)
                     | (32'(cfg.rev_c) << REVC_BIT);

  assign status_word = (32'(last_inc) << INC_LSB)
                     | (32'(code_known) << KNOWN_BIT);

  // Unmapped addresses read as zero and ignore writes
  assign next_hrdata = hit_select_rd ? select_word :
                       hit_status_rd ? status_word : 32'h0000_0000;

  // Zero wait states: ready is low only in reset and high after it, and the response line never moves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // No error response: mapped or not, every access completes OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
    end
  end

  // Write address is kept for the data phase, one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
    end else begin
      wr_pend <= take_write & (haddr[31:8] == 24'h00_0000);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr <= 8'h00;
    end else begin
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take_read) begin
      hrdata <= next_hrdata;
    end
  end

  // Select register: written in the data phase of a word-sized write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg.event_code_field <= CODE_RESET;
    end else if (hit_select_wr) begin
      cfg.event_code_field <= hwdata[CODE_LSB +: CODE_W];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg.sub_event_mask <= MASK_RESET;
    end else if (hit_select_wr) begin
      cfg.sub_event_mask <= hwdata[MASK_LSB +: MASK_W];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg.rev_c <= REVC_RESET;
    end else if (hit_select_wr) begin
      cfg.rev_c <= hwdata[REVC_BIT];
    end
  end

  // Sub-event decode

  wire [MASK_W-1:0] m;
  wire              stlf_hit;
  wire              refill_hit;
  wire              nb_refill_hit;
  wire              evict_state_hit;
  wire              evict_source_hit;
  wire              evict_valid;
  wire [1:0]        evict_source;
  wire              tlb_l2_hit;
  wire              tlb_miss_hit;
  wire              ecc_hit;
  wire              prefetch_hit;
  wire [2:0]        prefetch_counted;
  wire [2:0]        tlb_l2_mask;
  wire [4:0]        refill_strobes;
  wire              nb_refill_any;
  wire              first_miss;
  wire              stream_miss;
  wire              miss_counted;
  wire              locked_miss;

  assign m = cfg.sub_event_mask;

  // Store-to-load forward cancels, one bit per cause
  event_mask_match #(.W(3)) u_stlf (
    .strobes (events.stlf_cancel),
    .mask    (m[2:0]),
    .hit     (stlf_hit)
  );

  // Bit 0 is the sum of every northbridge refill state
  assign nb_refill_any  = |events.refill_nb_state;
  assign refill_strobes = {events.refill_l2_state, nb_refill_any};

  event_mask_match #(.W(5)) u_refill (
    .strobes (refill_strobes),
    .mask    (m[4:0]),
    .hit     (refill_hit)
  );

  event_mask_match #(.W(5)) u_nb_refill (
    .strobes (events.refill_nb_state),
    .mask    (m[4:0]),
    .hit     (nb_refill_hit)
  );

  event_mask_match #(.W(5)) u_evict_state (
    .strobes (events.evict_state),
    .mask    (m[4:0]),
    .hit     (evict_state_hit)
  );

  // Source bits count every eviction regardless of state
  assign evict_valid  = |events.evict_state;
  assign evict_source = {evict_valid & ~events.evict_nontemporal,
                         evict_valid & events.evict_nontemporal};

  // Mixed masks are not blocked; an eviction then counts once, not twice
  event_mask_match #(.W(2)) u_evict_source (
    .strobes (evict_source),
    .mask    (m[6:5]),
    .hit     (evict_source_hit)
  );

  // The 1G bit is reserved on the earlier revision
  assign tlb_l2_mask = {m[2] & cfg.rev_c, m[1:0]};

  event_mask_match #(.W(3)) u_tlb_l2 (
    .strobes (events.tlb_l2_hit),
    .mask    (tlb_l2_mask),
    .hit     (tlb_l2_hit)
  );

  // Both DTLB levels missed; each page size has its own bit
  event_mask_match #(.W(3)) u_tlb_miss (
    .strobes (events.tlb_miss),
    .mask    (m[2:0]),
    .hit     (tlb_miss_hit)
  );

  // Corrected errors, by the path that fixed them
  event_mask_match #(.W(4)) u_ecc (
    .strobes (events.ecc_corrected),
    .mask    (m[3:0]),
    .hit     (ecc_hit)
  );

  // A collision with a hardware prefetch drops every kind that cycle
  assign prefetch_counted = events.prefetch_dispatch & {3{~events.prefetch_collide}};

  event_mask_match #(.W(3)) u_prefetch (
    .strobes (prefetch_counted),
    .mask    (m[2:0]),
    .hit     (prefetch_hit)
  );

  // Miss filtering: non-streaming repeats to a line under refill are dropped
  assign first_miss   = events.dc_miss & ~events.miss_streaming & ~events.miss_line_pending;
  assign stream_miss  = events.dc_miss & events.miss_streaming & ~cfg.rev_c;
  assign miss_counted = first_miss | stream_miss;
  assign locked_miss  = events.dc_miss & events.miss_locked & m[1];

  // Event selection

  logic [1:0] next_inc;
  logic       next_known;

  // Codes outside this set select nothing and report as unknown
  always_comb begin
    next_inc   = 2'h0;
    next_known = 1'b1;
    case (cfg.event_code_field)
      EV_CLFLUSH: begin
        next_inc = {1'b0, events.clflush_retired};
      end
      EV_CPUID: begin
        next_inc = {1'b0, events.cpuid_retired};
      end
      EV_STLF: begin
        next_inc = {1'b0, stlf_hit};
      end
      EV_SMI: begin
        next_inc = {1'b0, events.smi_received};
      end
      EV_ACCESS: begin
        // A crossing access costs a second eight-byte access
        next_inc = {1'b0, events.dc_access} + {1'b0, events.misaligned};
      end
      EV_MISS: begin
        next_inc = {1'b0, miss_counted};
      end
      EV_REFILL: begin
        next_inc = {1'b0, refill_hit};
      end
      EV_NB_REFILL: begin
        next_inc = {1'b0, nb_refill_hit};
      end
      EV_EVICT: begin
        next_inc = {1'b0, evict_state_hit | evict_source_hit};
      end
      EV_TLB_L2HIT: begin
        next_inc = {1'b0, tlb_l2_hit};
      end
      EV_TLB_MISS: begin
        next_inc = {1'b0, tlb_miss_hit};
      end
      EV_MISALIGN: begin
        next_inc = {1'b0, events.misaligned};
      end
      EV_ECC: begin
        next_inc = {1'b0, ecc_hit};
      end
      EV_PREFETCH: begin
        next_inc = {1'b0, prefetch_hit};
      end
      EV_LOCK_MISS: begin
        next_inc = {1'b0, locked_miss};
      end
      default: begin
        next_inc   = 2'h0;
        next_known = 1'b0;
      end
    endcase
  end

  // One cycle from strobe to increment; the counter adds count_increment
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_increment <= 2'h0;
    end else begin
      count_increment <= next_inc;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_known <= 1'b0;
    end else begin
      code_known <= next_known;
    end
  end

  // Status copy; a read shows the increment of the cycle before its address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_inc <= 2'h0;
    end else begin
      last_inc <= next_inc;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/dcache_perf_monitor.sv ====
// Checker for the data cache event selector, bound to its top module.
// Assumes single-word AHB writes reach the select register at offset 0.
`timescale 1ns/1ns
`default_nettype none
module dcache_perf_monitor
  import dcache_perf_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire ls_events_s  events,
  input wire logic [1:0]  count_increment,
  input wire logic        code_known
);
  logic              pend;
  logic [CODE_W-1:0] code;
  logic [MASK_W-1:0] mask;
  logic              rev_c;
  // Shadow select register, so checks know what software chose
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend  <= 1'b0;
      code  <= CODE_RESET;
      mask  <= MASK_RESET;
      rev_c <= REVC_RESET;
    end else begin
      pend <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite && hsize == 3'h2 && haddr == 32'h0000_0000;
      if (pend) begin
        code  <= hwdata[CODE_LSB +: CODE_W];
        mask  <= hwdata[MASK_LSB +: MASK_W];
        rev_c <= hwdata[REVC_BIT];
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_unknown_silent: assert property (!code_known |-> count_increment == 2'h0)
    else $error("increment while code unknown");
  a_idle_zero: assert property (events == '0 |=> count_increment == 2'h0)
    else $error("increment without strobe");
  a_smi_one: assert property (code == EV_SMI && events.smi_received |=> count_increment == 2'h1)
    else $error("interrupt not counted");
  a_flush_follow: assert property (code == EV_CLFLUSH |=> count_increment == {1'b0, $past(events.clflush_retired)})
    else $error("flush count wrong");
  a_access_sum: assert property (code == EV_ACCESS |=>
    count_increment == {1'b0, $past(events.dc_access)} + {1'b0, $past(events.misaligned)})
    else $error("access count wrong");
  a_pending_miss: assert property (code == EV_MISS && events.miss_line_pending && !events.miss_streaming |=>
    count_increment == 2'h0)
    else $error("pending miss counted");
  a_stream_revc: assert property (code == EV_MISS && rev_c && events.miss_streaming |=> count_increment == 2'h0)
    else $error("streaming miss counted");
  a_lock_mask: assert property (code == EV_LOCK_MISS && !mask[1] |=> count_increment == 2'h0)
    else $error("locked miss without mask");
  c_double: cover property (count_increment == 2'h2);
  c_smi: cover property (code == EV_SMI && events.smi_received);
  c_stream: cover property (code == EV_MISS && !rev_c && events.miss_streaming);
endmodule
bind dcache_perf_event_select dcache_perf_monitor dcache_perf_monitor_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .events, .count_increment, .code_known);
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench: AHB register tasks plus one-cycle event strobes.
// Assumes one slave, hready fed back from hreadyout, zero wait states.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dcache_perf_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  ls_events_s  events = '0;
  ls_events_s  e = '0;
  logic [1:0]  count_increment;
  logic        code_known;
  logic [31:0] rd;
  int          miscompares = 0;
  int          check_count = 0;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  dcache_perf_event_select dcache_perf_event_select_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .events, .count_increment, .code_known);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Address phase, then data phase; each held until hready is sampled high
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Select an event, strobe e for one cycle, check the increment one edge later
  task automatic run(input logic [11:0] c, input logic [7:0] m, input logic rc, input logic [1:0] exp);
    xfer(32'h0, 1'b1, {rc, 7'h00, m, 4'h0, c}, 3'h2);
    events <= e;
    @(posedge hclk);
    events <= '0;
    e = '0;
    // Look at the increment mid-cycle, then realign to the rising edge
    @(negedge hclk);
    chk({30'h0, count_increment}, {30'h0, exp});
    chk({31'h0, code_known}, 32'h1);
    @(posedge hclk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(32'h0, 1'b0, 32'h0, 3'h2);
    chk(rd, 32'h8000_0000);
    xfer(32'h4, 1'b0, 32'h0, 3'h2);
    chk(rd, 32'h0000_0000);
    xfer(32'h0, 1'b1, 32'h00FF_002B, 3'h1);
    xfer(32'h8, 1'b1, 32'h1234_5678, 3'h2);
    xfer(32'h0, 1'b0, 32'h0, 3'h2);
    chk(rd, 32'h8000_0000);
    xfer(32'h8, 1'b0, 32'h0, 3'h2);
    chk(rd, 32'h0000_0000);
    $display("register test done");
    e = '1;
    xfer(32'h0, 1'b1, 32'h00FF_0000, 3'h2);
    events <= e;
    @(posedge hclk);
    events <= '0;
    e = '0;
    @(negedge hclk);
    chk({30'h0, count_increment}, 32'h0);
    chk({31'h0, code_known}, 32'h0);
    @(posedge hclk);
    e.clflush_retired = 1'b1;
    run(EV_CLFLUSH, 8'h00, 1'b1, 2'h1);
    e.cpuid_retired = 1'b1;
    run(EV_CPUID, 8'h00, 1'b1, 2'h1);
    e.cpuid_retired = 1'b1;
    run(EV_CLFLUSH, 8'h00, 1'b1, 2'h0);
    e.stlf_cancel = 3'h1;
    run(EV_STLF, 8'h01, 1'b1, 2'h1);
    e.stlf_cancel = 3'h3;
    run(EV_STLF, 8'h04, 1'b1, 2'h0);
    e.stlf_cancel = 3'h6;
    run(EV_STLF, 8'h06, 1'b1, 2'h1);
    e.smi_received = 1'b1;
    run(EV_SMI, 8'h00, 1'b1, 2'h1);
    xfer(32'h4, 1'b0, 32'h0, 3'h2);
    chk(rd, 32'h0000_0100);
    e.dc_access = 1'b1;
    run(EV_ACCESS, 8'h00, 1'b1, 2'h1);
    e.dc_access = 1'b1;
    e.misaligned = 1'b1;
    run(EV_ACCESS, 8'h00, 1'b1, 2'h2);
    e.misaligned = 1'b1;
    run(EV_MISALIGN, 8'h00, 1'b1, 2'h1);
    $display("retire and access test done");
    e.dc_miss = 1'b1;
    run(EV_MISS, 8'h00, 1'b1, 2'h1);
    e.dc_miss = 1'b1;
    e.miss_line_pending = 1'b1;
    run(EV_MISS, 8'h00, 1'b1, 2'h0);
    e.dc_miss = 1'b1;
    e.miss_streaming = 1'b1;
    run(EV_MISS, 8'h00, 1'b1, 2'h0);
    e.dc_miss = 1'b1;
    e.miss_streaming = 1'b1;
    run(EV_MISS, 8'h00, 1'b0, 2'h1);
    e.dc_miss = 1'b1;
    e.miss_locked = 1'b1;
    run(EV_LOCK_MISS, 8'h02, 1'b1, 2'h1);
    e.dc_miss = 1'b1;
    e.miss_locked = 1'b1;
    run(EV_LOCK_MISS, 8'h01, 1'b1, 2'h0);
    e.dc_miss = 1'b1;
    e.miss_locked = 1'b1;
    run(EV_MISS, 8'h00, 1'b1, 2'h1);
    e.refill_nb_state = 5'h10;
    run(EV_REFILL, 8'h01, 1'b1, 2'h1);
    e.refill_l2_state = 4'h8;
    run(EV_REFILL, 8'h10, 1'b1, 2'h1);
    e.refill_l2_state = 4'h8;
    run(EV_REFILL, 8'h02, 1'b1, 2'h0);
    e.refill_nb_state = 5'h01;
    run(EV_NB_REFILL, 8'h01, 1'b1, 2'h1);
    e.refill_nb_state = 5'h10;
    run(EV_NB_REFILL, 8'h0F, 1'b1, 2'h0);
    $display("miss and refill test done");
    e.evict_state = 5'h04;
    e.evict_nontemporal = 1'b1;
    run(EV_EVICT, 8'h20, 1'b1, 2'h1);
    e.evict_state = 5'h04;
    e.evict_nontemporal = 1'b1;
    run(EV_EVICT, 8'h40, 1'b1, 2'h0);
    e.evict_state = 5'h08;
    run(EV_EVICT, 8'h08, 1'b1, 2'h1);
    e.tlb_l2_hit = 3'h4;
    run(EV_TLB_L2HIT, 8'h04, 1'b1, 2'h1);
    e.tlb_l2_hit = 3'h4;
    run(EV_TLB_L2HIT, 8'h04, 1'b0, 2'h0);
    e.tlb_miss = 3'h2;
    run(EV_TLB_MISS, 8'h02, 1'b1, 2'h1);
    e.ecc_corrected = 4'h8;
    run(EV_ECC, 8'h08, 1'b1, 2'h1);
    e.prefetch_dispatch = 3'h4;
    run(EV_PREFETCH, 8'h04, 1'b1, 2'h1);
    e.prefetch_dispatch = 3'h4;
    e.prefetch_collide = 1'b1;
    run(EV_PREFETCH, 8'h04, 1'b1, 2'h0);
    $display("evict tlb ecc prefetch test done");
    // Mid-run reset: outputs drop at once and the select register returns to its reset value
    hresetn <= 1'b0;
    @(negedge hclk);
    chk({29'h0, hreadyout, count_increment}, 32'h0);
    chk({31'h0, code_known}, 32'h0);
    chk(hrdata, 32'h0000_0000);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(32'h0, 1'b0, 32'h0, 3'h2);
    chk(rd, 32'h8000_0000);
    xfer(32'h4, 1'b0, 32'h0, 3'h2);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
